// ==== hw/lcdts_defines.vh ====
// Constants for the LCD display-timing master/slave block.
// Assumes inclusion by bare name; definitions only.
`ifndef LCDTS_DEFINES_VH
`define LCDTS_DEFINES_VH

// ----------------------------------------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LCDTS_CTRL_OFS      12'h000
`define LCDTS_STATUS_OFS    12'h004
`define LCDTS_DIV_OFS       12'h008
`define LCDTS_LINES_OFS     12'h00c
`define LCDTS_POS_OFS       12'h010

// ----------------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------------
`define LCDTS_CTRL_DISP_ON  0
`define LCDTS_CTRL_STATIC   1
`define LCDTS_CTRL_RST      32'h00000000
`define LCDTS_DIV_RST       16'h0008
`define LCDTS_LINES_RST     7'h40

// ----------------------------------------------------------------------
// Timing: simulated reference-clock period in ns (bench display-clock link is 80 ns)
// ----------------------------------------------------------------------
`define LCDTS_CLK_PERIOD_NS 4
`define LCDTS_SYNC_STAGES   2

`endif

// ==== hw/lcdts_sync.v ====
// Two-flop synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module lcdts_sync #(
    parameter W = 1
) (
    input  wire         ref_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);
    reg [W-1:0] meta_q;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule // lcdts_sync
`default_nettype wire

// ==== hw/lcdts_top.v ====
// Display-timing master/slave core of a dot-matrix LCD driver.
// Assumes straps are stable pins; shared pins resolve externally from _oe.
//
// Behaviour
// - Strap high: internal oscillator times master display
// - Strap low: time display from clock pin
// - Master drives frame and blanking; clock only with oscillator
// - Slave takes timing from master, generates none
// - Clock pin is timing clock input, output in oscillator master
// - Frame polarity output in master, input slave
// - Blanking pin output in master, input slave
// - Static drive only when indicator on, master
// - Resistor strap honoured only in master mode
// - Power-mode strap honoured only in master mode
// - Commons zero to sixty-three, identical both roles
// - Segments zero to one hundred thirty-one
// - Both indicator commons carry same waveform
`timescale 1ns/10ps
`default_nettype none
`include "lcdts_defines.vh"
module lcdts_top #(
    parameter NCOM = 64,
    parameter NSEG = 132
) (
    input  wire            ref_clk_i,
    input  wire            rst_i,
    input  wire            osc_select_strap_i,
    input  wire            master_strap_i,
    input  wire            resistor_select_strap_i,
    input  wire            power_mode_n_i,
    input  wire            display_clock_pin_i,
    output reg             display_clock_pin_o,
    output reg             display_clock_pin_oe_o,
    input  wire            frame_polarity_signal_i,
    output reg             frame_polarity_signal_o,
    output reg             frame_polarity_signal_oe_o,
    input  wire            display_blank_n_i,
    output reg             display_blank_n_o,
    output reg             display_blank_n_oe_o,
    output reg             static_drive_out_o,
    output reg             int_resistor_en_o,
    output reg             high_power_en_o,
    output reg  [NCOM-1:0] common_outputs_o,
    output reg  [NSEG-1:0] segment_outputs_o,
    output reg  [1:0]      indicator_common_out_o,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [11:0]     paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    wire [6:0] pins_s;
    lcdts_sync #(.W(7)) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .async_i   ({osc_select_strap_i, master_strap_i, resistor_select_strap_i,
                     power_mode_n_i, display_clock_pin_i,
                     frame_polarity_signal_i, display_blank_n_i}),
        .sync_o    (pins_s)
    );
    wire osc_sel    = pins_s[6];
    wire master     = pins_s[5];
    wire irs_s      = pins_s[4];
    wire hpm_n_s    = pins_s[3];
    wire clk_pin_s  = pins_s[2];
    wire fr_in_s    = pins_s[1];
    wire blank_in_s = pins_s[0];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [31:0] ctrl_q;
    reg [15:0] div_q;
    reg [6:0]  lines_q;
    reg [15:0] osc_cnt_q;
    reg        osc_q;
    reg        clk_prev_q;
    reg        fr_prev_q;
    reg [6:0]  line_q;
    reg        fr_q;

    function is_addr;
        input [11:0] a;
        input [11:0] ofs;
        begin
            is_addr = (a == ofs);
        end
    endfunction

    wire apb_wr = psel & penable & pwrite;
    wire mapped = is_addr(paddr, `LCDTS_CTRL_OFS) | is_addr(paddr, `LCDTS_STATUS_OFS)
                | is_addr(paddr, `LCDTS_DIV_OFS) | is_addr(paddr, `LCDTS_LINES_OFS)
                | is_addr(paddr, `LCDTS_POS_OFS);

    // ------------------------------------------------------------------
    // APB slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q  <= `LCDTS_CTRL_RST;
            div_q   <= `LCDTS_DIV_RST;
            lines_q <= `LCDTS_LINES_RST;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (apb_wr & pready) begin
                if (is_addr(paddr, `LCDTS_CTRL_OFS))
                    ctrl_q <= {30'h00000000, pwdata[1:0]};
                if (is_addr(paddr, `LCDTS_DIV_OFS) && pwdata[15:0] != 16'h0000)
                    div_q <= pwdata[15:0];
                if (is_addr(paddr, `LCDTS_LINES_OFS) && pwdata[6:0] != 7'h00)
                    lines_q <= pwdata[6:0];
            end
            if (psel & ~penable & ~pwrite) begin
                if (is_addr(paddr, `LCDTS_CTRL_OFS))
                    prdata <= ctrl_q;
                else if (is_addr(paddr, `LCDTS_STATUS_OFS))
                    prdata <= {25'h0000000, osc_q, fr_q, display_blank_n_o, hpm_n_s,
                               irs_s, osc_sel, master};
                else if (is_addr(paddr, `LCDTS_DIV_OFS))
                    prdata <= {16'h0000, div_q};
                else if (is_addr(paddr, `LCDTS_LINES_OFS))
                    prdata <= {25'h0000000, lines_q};
                else if (is_addr(paddr, `LCDTS_POS_OFS))
                    prdata <= {24'h000000, fr_q, line_q};
                else
                    prdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Internal oscillator, halted while the strap selects the pin
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i || !osc_sel) begin
            osc_cnt_q <= 16'h0000;
            osc_q     <= 1'b0;
        end else if (osc_cnt_q >= div_q - 16'h0001) begin
            osc_cnt_q <= 16'h0000;
            osc_q     <= ~osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 16'h0001;
        end
    end

    // Slave always follows the pin; a master uses it only if strapped external
    wire use_pin   = ~master | ~osc_sel;
    wire clk_src   = use_pin ? clk_pin_s : osc_q;
    wire clk_rise  = clk_src & ~clk_prev_q;
    wire fr_edge   = fr_in_s ^ fr_prev_q;
    wire last_line = (line_q == lines_q - 7'h01);

    // ------------------------------------------------------------------
    // Line and frame sequencing
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            clk_prev_q <= 1'b0;
            fr_prev_q  <= 1'b0;
            line_q     <= 7'h00;
            fr_q       <= 1'b0;
        end else begin
            clk_prev_q <= clk_src;
            fr_prev_q  <= fr_in_s;
            if (master) begin
                if (clk_rise) begin
                    line_q <= last_line ? 7'h00 : line_q + 7'h01;
                    if (last_line)
                        fr_q <= ~fr_q;
                end
            end else begin
                fr_q <= fr_in_s;
                if (fr_edge)
                    line_q <= 7'h00;
                else if (clk_rise)
                    line_q <= last_line ? 7'h00 : line_q + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared timing pins and master-only straps
    // ------------------------------------------------------------------
    wire blank_n = master ? ctrl_q[`LCDTS_CTRL_DISP_ON] : blank_in_s;
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            display_clock_pin_o        <= 1'b0;
            display_clock_pin_oe_o     <= 1'b0;
            frame_polarity_signal_o    <= 1'b0;
            frame_polarity_signal_oe_o <= 1'b0;
            display_blank_n_o          <= 1'b0;
            display_blank_n_oe_o       <= 1'b0;
            static_drive_out_o         <= 1'b0;
            int_resistor_en_o          <= 1'b0;
            high_power_en_o            <= 1'b0;
        end else begin
            // Master with own oscillator shares its clock on the tied pin
            display_clock_pin_o        <= osc_q;
            display_clock_pin_oe_o     <= master & osc_sel;
            frame_polarity_signal_o    <= fr_q;
            frame_polarity_signal_oe_o <= master;
            display_blank_n_o          <= blank_n;
            display_blank_n_oe_o       <= master;
            static_drive_out_o         <= master & ctrl_q[`LCDTS_CTRL_STATIC] & fr_q;
            int_resistor_en_o          <= master & irs_s;
            high_power_en_o            <= master & ~hpm_n_s;
        end
    end

    // ------------------------------------------------------------------
    // Common and segment drive: one-hot scan, polarity from frame signal
    // ------------------------------------------------------------------
    // Segments carry no RAM data here, so no column counter is kept
    genvar gi;
    generate
        for (gi = 0; gi < NCOM; gi = gi + 1) begin : g_com
            always @(posedge ref_clk_i) begin
                if (rst_i)
                    common_outputs_o[gi] <= 1'b0;
                else
                    common_outputs_o[gi] <= blank_n & ((line_q == gi) ^ fr_q);
            end
        end
        for (gi = 0; gi < NSEG; gi = gi + 1) begin : g_seg
            always @(posedge ref_clk_i) begin
                if (rst_i)
                    segment_outputs_o[gi] <= 1'b0;
                else
                    segment_outputs_o[gi] <= blank_n & fr_q;
            end
        end
    endgenerate

    // Indicator common is slot line_q == lines_q, one past the last scan slot, mirrored on both pins
    always @(posedge ref_clk_i) begin
        if (rst_i)
            indicator_common_out_o <= 2'b00;
        else
            indicator_common_out_o <= {2{blank_n & ((line_q == lines_q) ^ fr_q)}};
    end
endmodule // lcdts_top
`default_nettype wire

// ==== test/lcdts_chk.sv ====
// Checker for strap handling, pin direction and APB answer timing.
// Assumes straps are held steady a few clocks before they are judged.
`timescale 1ns/10ps
`default_nettype none
module lcdts_chk (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       master_strap_i,
    input wire logic       osc_select_strap_i,
    input wire logic       resistor_select_strap_i,
    input wire logic       power_mode_n_i,
    input wire logic       display_clock_pin_oe_o,
    input wire logic       frame_polarity_signal_oe_o,
    input wire logic       display_blank_n_oe_o,
    input wire logic       static_drive_out_o,
    input wire logic       int_resistor_en_o,
    input wire logic       high_power_en_o,
    input wire logic [1:0] indicator_common_out_o,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Five cycles covers the two sync stages plus the output register
    sequence mst; master_strap_i [*5]; endsequence
    sequence slv; !master_strap_i [*5]; endsequence
    sequence apb_setup; psel && !penable; endsequence
    mst_drive_a: assert property (
        mst |-> frame_polarity_signal_oe_o && display_blank_n_oe_o) else $error("master idle");
    slv_quiet_a: assert property (
        slv |-> !(frame_polarity_signal_oe_o || display_blank_n_oe_o
                  || display_clock_pin_oe_o || static_drive_out_o)) else $error("slave drives");
    osc_drive_a: assert property (
        (master_strap_i && osc_select_strap_i) [*5] |-> display_clock_pin_oe_o)
        else $error("clock not driven");
    pin_clock_a: assert property (
        (!osc_select_strap_i) [*5] |-> !display_clock_pin_oe_o) else $error("clock pin driven");
    res_sel_a: assert property (
        (master_strap_i && resistor_select_strap_i) [*5] |-> int_resistor_en_o)
        else $error("resistor strap lost");
    slv_straps_a: assert property (
        slv |-> !int_resistor_en_o && !high_power_en_o) else $error("slave strap honoured");
    hpm_sel_a: assert property (
        (master_strap_i && !power_mode_n_i) [*5] |-> high_power_en_o) else $error("power lost");
    hpm_norm_a: assert property (
        power_mode_n_i [*5] |-> !high_power_en_o) else $error("power stuck high");
    ind_same_a: assert property (
        indicator_common_out_o[0] == indicator_common_out_o[1]) else $error("indicators differ");
    apb_ready_a: assert property (
        apb_setup ##1 (psel && penable) |-> pready) else $error("no ready");
endmodule // lcdts_chk
bind lcdts_top lcdts_chk chk_u (.*);
`default_nettype wire

// ==== test/lcdts_peer.sv ====
// Model of a companion chip sharing the clock, polarity and blanking pins.
// Assumes the block's _oe outputs decide who drives each shared pin.
`timescale 1ns/10ps
`default_nettype none
module lcdts_peer (
    input  wire logic run_i,
    input  wire logic clk_oe_i,
    input  wire logic clk_i,
    input  wire logic fr_oe_i,
    input  wire logic fr_i,
    input  wire logic blank_oe_i,
    input  wire logic blank_i,
    output logic      clk_pin_o,
    output logic      fr_pin_o,
    output logic      blank_pin_o
);
    logic clk_q = 1'h0;
    logic fr_q  = 1'h0;
    int   n     = 0;
    // Runs only while run_i is high, always halts low, offset from the core grid
    initial begin
        #1;
        forever begin
            #40;
            if (run_i || clk_q) begin
                clk_q = ~clk_q;
                if (clk_q && ++n % 8 == 0) fr_q = ~fr_q;
            end
        end
    end
    assign clk_pin_o   = clk_oe_i ? clk_i : clk_q;
    assign fr_pin_o    = fr_oe_i ? fr_i : fr_q;
    assign blank_pin_o = blank_oe_i ? blank_i : 1'h1;
endmodule // lcdts_peer
`default_nettype wire

// ==== test/lcdts_tb_top.sv ====
// Self-checking bench: master, pin-clocked master and slave roles.
// Assumes the peer model drives each shared pin the block leaves free.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin n_compared++; if ((a)!==(b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end
module lcdts_tb_top;
    logic ref_clk_i = 1'h0, rst_i = 1'h1, osc_select_strap_i = 1'h1, master_strap_i = 1'h1;
    logic resistor_select_strap_i = 1'h1, power_mode_n_i = 1'h0, run = 1'h0, e;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0, prdata, r;
    wire          display_clock_pin_i, frame_polarity_signal_i, display_blank_n_i;
    logic         display_clock_pin_o, display_clock_pin_oe_o, frame_polarity_signal_o;
    logic         frame_polarity_signal_oe_o, display_blank_n_o, display_blank_n_oe_o;
    logic         static_drive_out_o, int_resistor_en_o, high_power_en_o;
    logic [63:0]  common_outputs_o;
    logic [131:0] segment_outputs_o;
    logic [1:0]   indicator_common_out_o;
    int           fail_count = 0, n_compared = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    lcdts_top dut_u (.*);
    lcdts_peer peer_u (.run_i(run), .clk_oe_i(display_clock_pin_oe_o),
        .clk_i(display_clock_pin_o), .fr_oe_i(frame_polarity_signal_oe_o),
        .fr_i(frame_polarity_signal_o), .blank_oe_i(display_blank_n_oe_o),
        .blank_i(display_blank_n_o), .clk_pin_o(display_clock_pin_i),
        .fr_pin_o(frame_polarity_signal_i), .blank_pin_o(display_blank_n_i));
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk_i) penable <= 1'h1;
        k = 0;
        do @(posedge ref_clk_i); while (pready !== 1'h1 && ++k < 50);
        if (k >= 50) fail_count++;
        r = prdata; e = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        cyc(1);
    endtask
    task automatic straps(input logic m, o, i, p);
        master_strap_i <= m; osc_select_strap_i <= o;
        resistor_select_strap_i <= i; power_mode_n_i <= p;
        cyc(8);
    endtask
    task automatic t_bus;
        apb(0, 12'h020, 32'h0); `CHK(e, 1'h1)
        apb(1, 12'h00c, 32'h4); apb(0, 12'h00c, 32'h0); `CHK(r[6:0], 7'h04)
        apb(1, 12'h008, 32'h0); apb(0, 12'h008, 32'h0); `CHK(r[15:0], 16'h0008)
    endtask
    task automatic t_master;
        logic f; logic [31:0] p;
        straps(1, 1, 1, 0);
        `CHK({display_clock_pin_oe_o, frame_polarity_signal_oe_o, display_blank_n_oe_o}, 3'h7)
        `CHK({int_resistor_en_o, high_power_en_o}, 2'h3)
        apb(1, 12'h000, 32'h3); apb(0, 12'h010, 32'h0); p = r; cyc(20);
        `CHK(display_blank_n_o, 1'h1)
        apb(0, 12'h010, 32'h0); `CHK(r !== p, 1'h1)
        repeat (6) begin
            cyc(13); f = frame_polarity_signal_o; cyc(1);
            if (f === frame_polarity_signal_o) begin
                `CHK(static_drive_out_o, f)
                `CHK(segment_outputs_o, {132{f}})
            end
            `CHK($countones(common_outputs_o) inside {1, 63}, 1'h1)
            `CHK(indicator_common_out_o[0], indicator_common_out_o[1])
        end
    endtask
    task automatic t_pin_clock;
        logic [31:0] p;
        straps(1, 0, 1, 1);
        `CHK({display_clock_pin_oe_o, high_power_en_o}, 2'h0)
        apb(0, 12'h010, 32'h0); p = r; cyc(60);
        apb(0, 12'h010, 32'h0); `CHK(r, p)
        run <= 1'h1; cyc(60); apb(0, 12'h010, 32'h0); `CHK(r !== p, 1'h1)
        run <= 1'h0;
    endtask
    task automatic t_slave;
        logic [31:0] p;
        straps(0, 1, 1, 0);
        `CHK({display_clock_pin_oe_o, frame_polarity_signal_oe_o, display_blank_n_oe_o}, 3'h0)
        `CHK({int_resistor_en_o, high_power_en_o, static_drive_out_o}, 3'h0)
        cyc(80); apb(0, 12'h010, 32'h0); p = r; cyc(60);
        apb(0, 12'h010, 32'h0); `CHK(r, p)
        run <= 1'h1; cyc(100); apb(0, 12'h004, 32'h0); `CHK(r[5], frame_polarity_signal_i)
        apb(0, 12'h010, 32'h0); `CHK(r !== p, 1'h1)
        run <= 1'h0;
    endtask
    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        cyc(10);
        rst_i <= 1'h0;
        t_bus();
        t_master();
        t_pin_clock();
        t_slave();
        close_out();
    end
    // Whole run needs about 550 cycles; far beyond that means a hang
    initial begin
        cyc(20000);
        fail_count++;
        close_out();
    end
endmodule // lcdts_tb_top
`default_nettype wire
